//--- src/pbmr_map.svh
`ifndef PBMR_MAP_SVH
`define PBMR_MAP_SVH

// management register indices
`define PBMR_IDX_W          5
`define PBMR_IDX_CONTROL    5'h00
`define PBMR_IDX_STATUS     5'h01
`define PBMR_IDX_ID_HIGH    5'h02
`define PBMR_IDX_ID_LOW     5'h03

// control bit positions
`define PBMR_CTL_SRST       15
`define PBMR_CTL_LOOPBACK   14
`define PBMR_CTL_SPEED      13
`define PBMR_CTL_AN_EN      12
`define PBMR_CTL_PDOWN      11
`define PBMR_CTL_ISOLATE    10
`define PBMR_CTL_AN_RESTART 9
`define PBMR_CTL_DUPLEX     8
`define PBMR_CTL_COLTEST    7

// status bit positions
`define PBMR_STS_AN_DONE    5
`define PBMR_STS_RFAULT     4
`define PBMR_STS_LINK       2
`define PBMR_STS_JABBER     1

// fixed ability bits: 14..11, auto-negotiation ability (3), extended capability (0)
`define PBMR_STS_ABILITY    16'h7809
`define PBMR_STS_ABILITY_M  16'hFF09

// identifier reset values, arbitrary neutral codes
`define PBMR_ID_HIGH_RST    16'h0A5C
`define PBMR_ID_OUI_RST     6'h15
`define PBMR_ID_MODEL_RST   6'h2A
`define PBMR_ID_REV_RST     4'h1

// soft reset duration
`define PBMR_CLK_PERIOD_NS  20
`define PBMR_SRST_TIME_NS   320
`define PBMR_SRST_CYCLES    ((`PBMR_SRST_TIME_NS + `PBMR_CLK_PERIOD_NS - 1) / `PBMR_CLK_PERIOD_NS)

`endif

//--- src/pbmr_pkg.sv
package pbmr_pkg;

  typedef logic [15:0] pbmr_word_t;

  typedef enum logic [1:0] {
    PBMR_RUN  = 2'b01,
    PBMR_SRST = 2'b10
  } pbmr_state_e;

endpackage

//--- src/pbmr_latch_flag.sv
`timescale 1ns/100ps
module pbmr_latch_flag #(
  parameter bit LATCH_LOW = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic cond,
  input  wire logic rd_clear,
  output logic      flag
);

  logic next_flag;

  // a read re-arms the flag from the present condition, so an event in the
  // clearing cycle is kept
  always_comb begin
    if (rd_clear) begin
      next_flag = cond;
    end else if (LATCH_LOW) begin
      next_flag = flag & cond;
    end else begin
      next_flag = flag | cond;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  latch_hold_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (!LATCH_LOW && flag && !rd_clear) |=> flag)
    else $error("latch-high flag dropped before a read");

  latch_low_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (LATCH_LOW && !flag && !rd_clear) |=> !flag)
    else $error("latch-low flag rose before a read");

  read_follow_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_clear |=> (flag == $past(cond)))
    else $error("flag does not follow condition after read");

endmodule

//--- src/pbmr_regs.sv
// Operation
// - writing bit 15 runs self-clearing soft reset
// - soft reset keeps speed, enable, duplex register bits; clears bits 14, 11, 10, 7
// - bit 14 selects loopback, resets to zero
// - bit 13 speed, ignored under auto-negotiation
// - bit 12 enables auto-negotiation, overrides manual
// - bit 10 isolates the data interface
// - bit 9 restarts auto-negotiation, self-clears
// - bit 8 duplex, ignored under auto-negotiation
// - bit 7 collision test; bits 6:0 reserved
// - speed, enable, duplex reset from straps
// - ability bits 14:11 one; 15,10,9 zero
// - status bits 3,0 one; bit 8 zero
// - status bit 5 shows auto-negotiation done
// - status bit 4 latch-high remote fault
// - status bit 1 latch-high jabber
// - first identifier register, read/write
// - second identifier: oui, model, revision fields
// - latch-high holds until read, then follows
// - latch-low holds low until register read
`timescale 1ns/100ps
`include "pbmr_map.svh"
module pbmr_regs #(
  parameter int          RESET_CYCLES = `PBMR_SRST_CYCLES,
  parameter logic [15:0] ID_HIGH_RST  = `PBMR_ID_HIGH_RST,
  parameter logic [5:0]  ID_OUI_RST   = `PBMR_ID_OUI_RST,
  parameter logic [5:0]  ID_MODEL_RST = `PBMR_ID_MODEL_RST,
  parameter logic [3:0]  ID_REV_RST   = `PBMR_ID_REV_RST
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    strap_speed_100,
  input  wire logic                    strap_an_en,
  input  wire logic                    strap_full_duplex,
  input  wire logic [`PBMR_IDX_W-1:0]  reg_index,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [15:0]             reg_wdata,
  output logic      [15:0]             reg_rdata,
  output logic                         reg_rvalid,
  input  wire logic                    link_up,
  input  wire logic                    an_complete,
  input  wire logic                    remote_fault,
  input  wire logic                    jabber,
  output logic                         soft_reset,
  output logic                         loopback_en,
  output logic                         an_enable,
  output logic                         an_restart,
  output logic                         power_down,
  output logic                         mii_isolate,
  output logic                         col_test_en,
  output logic                         force_speed_100,
  output logic                         force_full_duplex,
  output logic                         force_valid
);

  localparam int CW        = $clog2(RESET_CYCLES + 1);
  localparam int SRST_LAST = RESET_CYCLES;

  if (RESET_CYCLES < 1 || RESET_CYCLES > 1000) begin : g_bad_reset_cycles
    $error("RESET_CYCLES must lie in 1..1000");
  end

  pbmr_pkg::pbmr_state_e state;
  pbmr_pkg::pbmr_state_e next_state;
  logic [CW-1:0]         srst_cnt;
  logic                  ctl_speed;
  logic                  ctl_duplex;
  logic [15:0]           id_high;
  logic [15:0]           id_low;
  logic                  rf_flag;
  logic                  link_flag;
  logic                  jab_flag;
  logic                  wr_ctl;
  logic                  srst_req;
  logic                  cfg_wr;
  logic                  sts_rd;
  logic [15:0]           next_rdata;

  function automatic logic sel(input logic [`PBMR_IDX_W-1:0] idx,
                               input logic [`PBMR_IDX_W-1:0] want);
    sel = (idx == want);
  endfunction

  // control writes are held off while soft reset runs
  assign wr_ctl   = reg_wr && sel(reg_index, `PBMR_IDX_CONTROL) && (state == pbmr_pkg::PBMR_RUN);
  assign srst_req = wr_ctl && reg_wdata[`PBMR_CTL_SRST];
  // a soft reset write takes no other bit from the data, even if the host set some
  assign cfg_wr   = wr_ctl && !reg_wdata[`PBMR_CTL_SRST];
  assign sts_rd   = reg_rd && sel(reg_index, `PBMR_IDX_STATUS);

  always_comb begin
    next_state = state;
    unique case (state)
      pbmr_pkg::PBMR_RUN: begin
        if (srst_req) begin
          next_state = pbmr_pkg::PBMR_SRST;
        end
      end
      pbmr_pkg::PBMR_SRST: begin
        if (srst_cnt == CW'(RESET_CYCLES - 1)) begin
          next_state = pbmr_pkg::PBMR_RUN;
        end
      end
      default: begin
        next_state = pbmr_pkg::PBMR_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state      <= pbmr_pkg::PBMR_RUN;
      srst_cnt   <= '0;
      soft_reset <= 1'b0;
    end else begin
      state      <= next_state;
      soft_reset <= (next_state == pbmr_pkg::PBMR_SRST);
      if (state == pbmr_pkg::PBMR_SRST) begin
        srst_cnt <= srst_cnt + CW'(1);
      end else begin
        srst_cnt <= '0;
      end
    end
  end

  // straps are taken only by the power-on reset; soft reset leaves these alone
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctl_speed  <= strap_speed_100;
      an_enable  <= strap_an_en;
      ctl_duplex <= strap_full_duplex;
    end else if (cfg_wr) begin
      ctl_speed  <= reg_wdata[`PBMR_CTL_SPEED];
      an_enable  <= reg_wdata[`PBMR_CTL_AN_EN];
      ctl_duplex <= reg_wdata[`PBMR_CTL_DUPLEX];
    end
  end

  // soft reset returns the plain mode bits to zero; straps are not re-read
  always_ff @(posedge ref_clk) begin
    if (!resetn || srst_req) begin
      loopback_en <= 1'b0;
      power_down  <= 1'b0;
      mii_isolate <= 1'b0;
      col_test_en <= 1'b0;
    end else if (cfg_wr) begin
      loopback_en <= reg_wdata[`PBMR_CTL_LOOPBACK];
      power_down  <= reg_wdata[`PBMR_CTL_PDOWN];
      mii_isolate <= reg_wdata[`PBMR_CTL_ISOLATE];
      col_test_en <= reg_wdata[`PBMR_CTL_COLTEST];
    end
  end

  // one-cycle restart; it only reaches a running auto-negotiation
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= cfg_wr && reg_wdata[`PBMR_CTL_AN_RESTART]
                    && reg_wdata[`PBMR_CTL_AN_EN];
    end
  end

  // manual speed and duplex reach the core only with auto-negotiation off
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      force_valid       <= 1'b0;
      force_speed_100   <= 1'b0;
      force_full_duplex <= 1'b0;
    end else begin
      force_valid       <= !an_enable;
      force_speed_100   <= ctl_speed && !an_enable;
      force_full_duplex <= ctl_duplex && !an_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      id_high <= ID_HIGH_RST;
      id_low  <= {ID_OUI_RST, ID_MODEL_RST, ID_REV_RST};
    end else if (reg_wr && state == pbmr_pkg::PBMR_RUN) begin
      if (sel(reg_index, `PBMR_IDX_ID_HIGH)) begin
        id_high <= reg_wdata;
      end
      if (sel(reg_index, `PBMR_IDX_ID_LOW)) begin
        id_low <= reg_wdata;
      end
    end
  end

  pbmr_latch_flag #(
    .LATCH_LOW (1'b0)
  ) u_rfault (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .cond     (remote_fault),
    .rd_clear (sts_rd),
    .flag     (rf_flag)
  );

  pbmr_latch_flag #(
    .LATCH_LOW (1'b1)
  ) u_link (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .cond     (link_up),
    .rd_clear (sts_rd),
    .flag     (link_flag)
  );

  pbmr_latch_flag #(
    .LATCH_LOW (1'b0)
  ) u_jabber (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .cond     (jabber),
    .rd_clear (sts_rd),
    .flag     (jab_flag)
  );

  // reserved and unmapped locations read as zero
  always_comb begin
    next_rdata = 16'h0000;
    unique case (1'b1)
      sel(reg_index, `PBMR_IDX_CONTROL): begin
        next_rdata[`PBMR_CTL_SRST]     = (state == pbmr_pkg::PBMR_SRST);
        next_rdata[`PBMR_CTL_LOOPBACK] = loopback_en;
        next_rdata[`PBMR_CTL_SPEED]    = ctl_speed;
        next_rdata[`PBMR_CTL_AN_EN]    = an_enable;
        next_rdata[`PBMR_CTL_PDOWN]    = power_down;
        next_rdata[`PBMR_CTL_ISOLATE]  = mii_isolate;
        next_rdata[`PBMR_CTL_DUPLEX]   = ctl_duplex;
        next_rdata[`PBMR_CTL_COLTEST]  = col_test_en;
      end
      sel(reg_index, `PBMR_IDX_STATUS): begin
        next_rdata                   = `PBMR_STS_ABILITY;
        next_rdata[`PBMR_STS_AN_DONE] = an_complete;
        next_rdata[`PBMR_STS_RFAULT]  = rf_flag;
        next_rdata[`PBMR_STS_LINK]    = link_flag;
        next_rdata[`PBMR_STS_JABBER]  = jab_flag;
      end
      sel(reg_index, `PBMR_IDX_ID_HIGH): begin
        next_rdata = id_high;
      end
      sel(reg_index, `PBMR_IDX_ID_LOW): begin
        next_rdata = id_low;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  srst_length_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(soft_reset) |-> ##[1:SRST_LAST] !soft_reset)
    else $error("soft reset did not self-clear in time");

  srst_keep_cfg_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (soft_reset && $past(soft_reset)) |-> ($stable(an_enable) && $stable(ctl_speed)
                                           && $stable(ctl_duplex)))
    else $error("configuration changed during soft reset");

  loopback_wr_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_wr |=> (loopback_en == $past(reg_wdata[`PBMR_CTL_LOOPBACK])))
    else $error("loopback bit not taken from write");

  manual_ignored_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(an_enable) |-> (!force_speed_100 && !force_full_duplex && !force_valid))
    else $error("manual speed or duplex used under auto-negotiation");

  restart_pulse_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    an_restart |-> (an_enable ##1 (!an_restart || $past(cfg_wr))))
    else $error("restart not a single cycle with auto-negotiation on");

  isolate_wr_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_wr |=> (mii_isolate == $past(reg_wdata[`PBMR_CTL_ISOLATE])))
    else $error("isolate bit not taken from write");

  status_fixed_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (reg_rd && sel(reg_index, `PBMR_IDX_STATUS)) |=>
      ((reg_rdata & `PBMR_STS_ABILITY_M) == `PBMR_STS_ABILITY))
    else $error("fixed ability bits wrong");

  an_done_rd_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (reg_rd && sel(reg_index, `PBMR_IDX_STATUS)) |=>
      (reg_rdata[`PBMR_STS_AN_DONE] == $past(an_complete)))
    else $error("completion bit does not match core");

  id_write_read_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (reg_wr && !reg_rd && state == pbmr_pkg::PBMR_RUN && sel(reg_index, `PBMR_IDX_ID_HIGH))
      ##1 (reg_rd && !reg_wr && sel(reg_index, `PBMR_IDX_ID_HIGH))
      |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("identifier write not read back");

  unmapped_zero_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (reg_rd && reg_index > `PBMR_IDX_ID_LOW) |=> (reg_rvalid && reg_rdata == 16'h0000))
    else $error("unmapped index did not read zero");

endmodule

//--- dv/pbmr_host.sv
`timescale 1ns/100ps
`include "pbmr_map.svh"
module pbmr_host (
  input  wire logic                   ref_clk,
  output logic      [`PBMR_IDX_W-1:0] reg_index,
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic      [15:0]            reg_wdata,
  input  wire logic [15:0]            reg_rdata,
  input  wire logic                   reg_rvalid
);
  initial begin
    reg_index = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // released index and data lines show the inverse, strobes drop to zero, so stale values never pass for data
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_index = ~reg_index;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [`PBMR_IDX_W-1:0] idx, input logic [15:0] d);
    @(negedge ref_clk);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    release_bus();
  endtask
  // write then read the same index in the very next cycle
  task automatic wr_rd(input logic [`PBMR_IDX_W-1:0] idx, input logic [15:0] d,
                       output logic [15:0] q, output logic ok);
    @(negedge ref_clk);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    release_bus();
    ok = (reg_rvalid === 1'b1);
    q = reg_rdata;
  endtask
  task automatic rd(input logic [`PBMR_IDX_W-1:0] idx, output logic [15:0] d, output logic ok);
    int n;
    @(negedge ref_clk);
    reg_index = idx;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    release_bus();
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask
endmodule

//--- dv/pbmr_regs_test.sv
`timescale 1ns/100ps
`include "pbmr_map.svh"
`define PBMR_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module pbmr_regs_test;
  localparam int          RST_CYC  = 2;
  // identifier values below are arbitrary
  localparam logic [15:0] ID_HI    = 16'h5A3C;
  localparam logic [5:0]  ID_OUI   = 6'h2D;
  localparam logic [5:0]  ID_MODEL = 6'h13;
  localparam logic [3:0]  ID_REV   = 4'h6;
  logic                   ref_clk;
  logic                   resetn;
  logic                   strap_speed_100;
  logic                   strap_an_en;
  logic                   strap_full_duplex;
  logic [`PBMR_IDX_W-1:0] reg_index;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [15:0]            reg_wdata;
  logic [15:0]            reg_rdata;
  logic                   reg_rvalid;
  logic                   link_up;
  logic                   an_complete;
  logic                   remote_fault;
  logic                   jabber;
  logic                   soft_reset;
  logic                   loopback_en;
  logic                   an_enable;
  logic                   an_restart;
  logic                   power_down;
  logic                   mii_isolate;
  logic                   col_test_en;
  logic                   force_speed_100;
  logic                   force_full_duplex;
  logic                   force_valid;
  logic [15:0]            d;
  logic                   ok;
  int                     num_errors;
  int                     checks;
  int                     cyc;
  int                     n;

  pbmr_regs #(.RESET_CYCLES(RST_CYC), .ID_HIGH_RST(ID_HI), .ID_OUI_RST(ID_OUI),
    .ID_MODEL_RST(ID_MODEL), .ID_REV_RST(ID_REV)) i_pbmr_regs (
    .ref_clk(ref_clk), .resetn(resetn), .strap_speed_100(strap_speed_100),
    .strap_an_en(strap_an_en), .strap_full_duplex(strap_full_duplex),
    .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_up(link_up),
    .an_complete(an_complete), .remote_fault(remote_fault), .jabber(jabber),
    .soft_reset(soft_reset), .loopback_en(loopback_en), .an_enable(an_enable),
    .an_restart(an_restart), .power_down(power_down), .mii_isolate(mii_isolate),
    .col_test_en(col_test_en), .force_speed_100(force_speed_100),
    .force_full_duplex(force_full_duplex), .force_valid(force_valid));

  pbmr_host i_pbmr_host (
    .ref_clk(ref_clk), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  always #10 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang in a handshake loop must not stall the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic rd_chk(input logic [`PBMR_IDX_W-1:0] idx, input logic [15:0] exp);
    i_pbmr_host.rd(idx, d, ok);
    `PBMR_CHK(ok, 1'b1)
    `PBMR_CHK(d, exp)
  endtask

  task automatic wait_srst();
    n = 0;
    while (soft_reset === 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    strap_speed_100 = 1'b1;
    strap_an_en = 1'b0;
    strap_full_duplex = 1'b1;
    link_up = 1'b0;
    an_complete = 1'b0;
    remote_fault = 1'b0;
    jabber = 1'b0;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    rd_chk(0, 16'h2100);
    `PBMR_CHK({an_enable, force_valid, force_speed_100, force_full_duplex}, 4'b0111)
    rd_chk(1, 16'h7809);
    rd_chk(2, ID_HI);
    rd_chk(3, {ID_OUI, ID_MODEL, ID_REV});
    i_pbmr_host.wr(2, 16'hC3A5);
    i_pbmr_host.wr(3, 16'h1E2D);
    rd_chk(2, 16'hC3A5);
    rd_chk(3, 16'h1E2D);
    i_pbmr_host.wr_rd(2, 16'h6B1D, d, ok);
    `PBMR_CHK(ok, 1'b1)
    `PBMR_CHK(d, 16'h6B1D)
    i_pbmr_host.wr(5, 16'hFFFF);
    rd_chk(5, 16'h0000);
    $display("test reset_and_id done");
    i_pbmr_host.wr(0, 16'h4580);
    @(negedge ref_clk);
    `PBMR_CHK({loopback_en, mii_isolate, col_test_en, force_speed_100, force_full_duplex, power_down}, 6'b111010)
    rd_chk(0, 16'h4580);
    i_pbmr_host.wr(0, 16'h0800);
    @(negedge ref_clk);
    `PBMR_CHK({power_down, loopback_en, mii_isolate, col_test_en, force_full_duplex}, 5'b10000)
    $display("test control_bits done");
    i_pbmr_host.wr(0, 16'h3300);
    `PBMR_CHK({an_restart, an_enable}, 2'b11)
    @(negedge ref_clk);
    `PBMR_CHK({an_restart, force_valid, force_speed_100, force_full_duplex}, 4'b0000)
    rd_chk(0, 16'h3100);
    $display("test auto_negotiation done");
    i_pbmr_host.wr(0, 16'h7100);
    i_pbmr_host.wr(0, 16'h8000);
    `PBMR_CHK({soft_reset, loopback_en}, 2'b10)
    rd_chk(0, 16'hB100);
    wait_srst();
    rd_chk(0, 16'h3100);
    i_pbmr_host.wr(0, 16'h8000);
    wait_srst();
    `PBMR_CHK(n, RST_CYC)
    $display("test soft_reset done");
    i_pbmr_host.wr(1, 16'h0000);
    link_up = 1'b1;
    an_complete = 1'b1;
    jabber = 1'b1;
    remote_fault = 1'b1;
    @(negedge ref_clk);
    jabber = 1'b0;
    remote_fault = 1'b0;
    @(negedge ref_clk);
    rd_chk(1, 16'h783B);
    rd_chk(1, 16'h782D);
    jabber = 1'b1;
    link_up = 1'b0;
    @(negedge ref_clk);
    link_up = 1'b1;
    @(negedge ref_clk);
    rd_chk(1, 16'h782B);
    rd_chk(1, 16'h782F);
    jabber = 1'b0;
    an_complete = 1'b0;
    @(negedge ref_clk);
    rd_chk(1, 16'h780F);
    rd_chk(1, 16'h780D);
    $display("test status_latches done");
    resetn = 1'b0;
    strap_speed_100 = 1'b0;
    strap_an_en = 1'b1;
    strap_full_duplex = 1'b0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    rd_chk(0, 16'h1000);
    `PBMR_CHK({an_enable, force_valid, force_speed_100, loopback_en}, 4'b1000)
    rd_chk(2, ID_HI);
    $display("test strap_reset done");
    report_and_stop();
  end
endmodule
